// ---- logic/table_base_regs.sv ----
// Purpose: Translation table base registers and walk attribute selection.
// Assumes: Coprocessor transfers arrive as one-cycle strobes in the core clock domain.
// Notes: Reads answer one cycle after the strobe.
`timescale 1ns/1ps
// Contract
// - The process base keeps bits 31 down to 14-N as its table pointer; lower bits up to 5 read zero.
// - Bits 4:3 of each base give the outer cache attribute of walk accesses.
// - Bit 1 marks walks as shared, and resets to non-shared.
// - Bit 0 makes walks inner cacheable, and resets to inner noncacheable.
// - Privileged reads return data and privileged writes update; user accesses are undefined.
// - The process base is selected by opcode 0, primary 2, secondary 0, second opcode 0.
// - The system base is selected by opcode 0, primary 2, secondary 0, second opcode 1.
// - The system base keeps bits 31:14 as its table pointer; bits 13:5 read zero.
// - Walks through the system base are always outer cacheable.
// - The walker never reads from the level one cache, even when inner cacheable.
// - A walk uses the process base when N is 0 or the top N address bits are zero.
// - N is three bits from 0 to 7 and resets to 0.
module table_base_regs (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Coprocessor transfer
   input wire logic i_xfer_valid,
   input wire logic i_xfer_write,
   input wire logic i_privileged,
   input wire logic [2:0] i_opc1,
   input wire logic [3:0] i_primary_coproc_reg,
   input wire logic [3:0] i_secondary_coproc_reg,
   input wire logic [2:0] i_opc2,
   input wire logic [31:0] i_wdata,
   output logic o_rvalid,
   output logic [31:0] o_rdata,
   output logic o_undefined,
   // Table walk
   input wire logic i_walk_req,
   input wire logic [31:0] i_walk_vaddr,
   output logic o_walk_valid,
   output logic [31:0] o_walk_addr,
   output logic o_walk_use_system,
   output logic [1:0] o_walk_outer_attr,
   output logic o_walk_shared,
   output logic o_walk_inner_cache,
   output logic o_walk_l1_bypass,
   // Current state
   output logic [31:0] o_process_table_base,
   output logic [31:0] o_system_table_base,
   output logic [2:0] o_table_boundary_control
);
   logic rst_meta;
   logic rst_sync_n;
   logic [31:0] process_table_base;
   logic [31:0] system_table_base;
   logic [2:0] table_boundary_control;
   logic [31:0] next_process_table_base;
   logic [31:0] next_system_table_base;
   logic [2:0] next_table_boundary_control;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic next_undefined;
   logic next_walk_valid;
   logic [31:0] next_walk_addr;
   logic next_walk_use_system;
   logic [1:0] next_walk_outer_attr;
   logic next_walk_shared;
   logic next_walk_inner_cache;
   logic sel_use_system;
   logic [31:0] sel_addr;
   logic [1:0] sel_outer;
   logic sel_shared;
   logic sel_inner;
   logic hit_group;
   logic hit_process;
   logic hit_system;
   logic hit_boundary;
   logic [31:0] process_view;
   logic [31:0] system_view;
   wire logic [31:0] process_keep;
   wire logic [31:0] system_keep;
   logic xfer_hit;
   logic user_refused;
   logic priv_write;
   logic priv_read;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   table_select u_select (
      .i_vaddr(i_walk_vaddr),
      .i_boundary(table_boundary_control),
      .i_process_base(process_table_base),
      .i_system_base(system_table_base),
      .o_use_system(sel_use_system),
      .o_desc_addr(sel_addr),
      .o_outer_walk_attr(sel_outer),
      .o_shared(sel_shared),
      .o_inner_cache(sel_inner)
   );

   always_comb begin
      hit_group = (i_opc1 == table_base_pkg::OPC1_TABLE)
         && (i_primary_coproc_reg == table_base_pkg::PRIMARY_TABLE)
         && (i_secondary_coproc_reg == table_base_pkg::SECONDARY_TABLE);
      hit_process = hit_group && (i_opc2 == table_base_pkg::OPC2_PROCESS);
      hit_system = hit_group && (i_opc2 == table_base_pkg::OPC2_SYSTEM);
      hit_boundary = hit_group && (i_opc2 == table_base_pkg::OPC2_BOUNDARY);
      xfer_hit = i_xfer_valid && (hit_process || hit_system || hit_boundary);
      user_refused = xfer_hit && !i_privileged;
      // Only a privileged write may move a store, so a refused user write leaves all of them.
      priv_write = xfer_hit && i_privileged && i_xfer_write;
      priv_read = xfer_hit && i_privileged && !i_xfer_write;
      // Pointer bits below 14-N read back as zero.
      process_view = process_table_base & process_keep;
      system_view = system_table_base & system_keep;
   end

   for (genvar b = 0; b < 32; b++) begin : g_keep
      if (b >= table_base_pkg::SYS_BASE_LSB) begin : g_pointer
         assign process_keep[b] = 1'b1;
         assign system_keep[b] = 1'b1;
      end else if (b > table_base_pkg::ATTR_MSB) begin : g_sized
         // The process pointer reaches down to bit 14-N, one bit further for each step of N.
         assign process_keep[b] = (5'(b) + {2'b00, table_boundary_control})
            >= 5'(table_base_pkg::SYS_BASE_LSB);
         assign system_keep[b] = 1'b0;
      end else begin : g_attr
         assign process_keep[b] = table_base_pkg::ATTR_MASK[b];
         assign system_keep[b] = table_base_pkg::ATTR_MASK[b];
      end
   end

   always_comb begin
      next_process_table_base = process_table_base;
      next_system_table_base = system_table_base;
      next_table_boundary_control = table_boundary_control;
      if (priv_write && hit_process) begin
         // The word is stored with bit 2 cleared so a later larger N exposes written pointer bits.
         next_process_table_base = i_wdata & ~32'h0000_0004;
      end else if (priv_write && hit_system) begin
         next_system_table_base = i_wdata & system_keep;
      end else if (priv_write && hit_boundary) begin
         next_table_boundary_control = i_wdata[2:0];
      end
   end

   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         process_table_base <= table_base_pkg::PROCESS_RESET;
         system_table_base <= table_base_pkg::SYSTEM_RESET;
         table_boundary_control <= table_base_pkg::BOUNDARY_RESET;
         o_process_table_base <= table_base_pkg::PROCESS_RESET;
         o_system_table_base <= table_base_pkg::SYSTEM_RESET;
         o_table_boundary_control <= table_base_pkg::BOUNDARY_RESET;
      end else begin
         process_table_base <= next_process_table_base;
         system_table_base <= next_system_table_base;
         table_boundary_control <= next_table_boundary_control;
         // The copies load the same next values, so they never lag the stores.
         o_process_table_base <= next_process_table_base;
         o_system_table_base <= next_system_table_base;
         o_table_boundary_control <= next_table_boundary_control;
      end
   end

   always_comb begin
      next_rvalid = priv_read;
      next_undefined = user_refused;
      next_rdata = 32'h0000_0000;
      if (priv_read && hit_process) begin
         next_rdata = process_view;
      end else if (priv_read && hit_system) begin
         next_rdata = system_view;
      end else if (priv_read && hit_boundary) begin
         next_rdata = {29'h0, table_boundary_control};
      end
   end

   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_rvalid <= 1'b0;
         o_rdata <= 32'h0000_0000;
         o_undefined <= 1'b0;
      end else begin
         o_rvalid <= next_rvalid;
         o_rdata <= next_rdata;
         o_undefined <= next_undefined;
      end
   end

   // The selector runs every cycle; o_walk_valid marks the cycle that answers a request.
   always_comb begin
      next_walk_valid = i_walk_req;
      next_walk_addr = sel_addr;
      next_walk_use_system = sel_use_system;
      next_walk_outer_attr = sel_outer;
      next_walk_shared = sel_shared;
      next_walk_inner_cache = sel_inner;
   end

   always_ff @(posedge i_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         o_walk_valid <= 1'b0;
         o_walk_addr <= 32'h0000_0000;
         o_walk_use_system <= 1'b0;
         o_walk_outer_attr <= 2'h0;
         o_walk_shared <= 1'b0;
         o_walk_inner_cache <= 1'b0;
         o_walk_l1_bypass <= 1'b1;
      end else begin
         o_walk_valid <= next_walk_valid;
         o_walk_addr <= next_walk_addr;
         o_walk_use_system <= next_walk_use_system;
         o_walk_outer_attr <= next_walk_outer_attr;
         o_walk_shared <= next_walk_shared;
         o_walk_inner_cache <= next_walk_inner_cache;
         // Walks always go past the level one cache, whatever the inner attribute says.
         o_walk_l1_bypass <= 1'b1;
      end
   end
endmodule : table_base_regs

// ---- logic/table_base_pkg.sv ----
// Purpose: Constants shared by the translation table base register bank.
// Assumes: Registers are reached by system coprocessor register transfers.
// Notes: Coprocessor numbers are kept as plain field values.
package table_base_pkg;
   localparam logic [2:0] OPC1_TABLE = 3'h0;
   localparam logic [3:0] PRIMARY_TABLE = 4'h2;
   localparam logic [3:0] SECONDARY_TABLE = 4'h0;
   localparam logic [2:0] OPC2_PROCESS = 3'h0;
   localparam logic [2:0] OPC2_SYSTEM = 3'h1;
   localparam logic [2:0] OPC2_BOUNDARY = 3'h2;
   localparam logic [31:0] PROCESS_RESET = 32'h0000_0000;
   localparam logic [31:0] SYSTEM_RESET = 32'h0000_0000;
   localparam logic [2:0] BOUNDARY_RESET = 3'h0;
   localparam int SYS_BASE_LSB = 14;
   localparam int ATTR_MSB = 4;
   localparam int ATTR_LSB = 3;
   localparam int SHARED_BIT = 1;
   localparam int INNER_BIT = 0;
   localparam logic [1:0] OUTER_NONCACHE = 2'h0;
   localparam logic [1:0] OUTER_WB_ALLOC = 2'h1;
   localparam logic [1:0] OUTER_WT_NOALLOC = 2'h2;
   localparam logic [1:0] OUTER_WB_NOALLOC = 2'h3;
   // Lower-bit mask kept per register: bits 4:0 hold attributes, bit 2 reserved.
   localparam logic [31:0] ATTR_MASK = 32'h0000_001b;
endpackage : table_base_pkg

// ---- logic/table_select.sv ----
// Purpose: Chooses the base register for a table walk and forms its descriptor address.
// Assumes: All inputs come from the same clock domain.
// Notes: Purely combinational; the top registers the result.
`timescale 1ns/1ps
module table_select (
   // Walk request
   input wire logic [31:0] i_vaddr,
   input wire logic [2:0] i_boundary,
   // Stored bases
   input wire logic [31:0] i_process_base,
   input wire logic [31:0] i_system_base,
   // Selection
   output logic o_use_system,
   output logic [31:0] o_desc_addr,
   output logic [1:0] o_outer_walk_attr,
   output logic o_shared,
   output logic o_inner_cache
);
   logic [31:0] top_mask;
   logic [31:0] base_mask;
   logic [31:0] index_bits;
   logic [31:0] base;

   always_comb begin
      // Ones in bits 31 down to 32-N of the address; empty when N is 0.
      top_mask = ~(32'hffff_ffff >> i_boundary);
      o_use_system = (i_boundary != 3'h0) && ((i_vaddr & top_mask) != 32'h0);
      base = o_use_system ? i_system_base : i_process_base;
      // The table pointer holds bits 31 down to 14-N for the process table.
      base_mask = o_use_system ? 32'hffff_c000 : ~(32'h0000_3fff >> i_boundary);
      // The system table is always a full 16KB one, so only process walks drop the top N bits.
      index_bits = ((i_vaddr << (o_use_system ? 3'h0 : i_boundary)) >> 20) << 2;
      o_desc_addr = (base & base_mask) | (index_bits & ~base_mask);
      o_outer_walk_attr = base[table_base_pkg::ATTR_MSB:table_base_pkg::ATTR_LSB];
      // Walks through the system table are always outer cacheable.
      if (o_use_system && (o_outer_walk_attr == table_base_pkg::OUTER_NONCACHE)) begin
         o_outer_walk_attr = table_base_pkg::OUTER_WB_NOALLOC;
      end
      o_shared = base[table_base_pkg::SHARED_BIT];
      o_inner_cache = base[table_base_pkg::INNER_BIT];
   end
endmodule : table_select

// ---- tb/table_base_regs_asserts.sv ----
// Purpose: Port-level checks of the table base register bank.
// Assumes: One clock domain; the bench keeps opcode 1, primary and secondary fixed.
// Notes: Attached by bind from the bench top.
`timescale 1ns/1ps
module table_base_regs_asserts (
   // Clock, reset and transfer
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_xfer_valid,
   input wire logic i_xfer_write,
   input wire logic i_privileged,
   input wire logic [2:0] i_opc1,
   input wire logic [3:0] i_primary_coproc_reg,
   input wire logic [3:0] i_secondary_coproc_reg,
   input wire logic [2:0] i_opc2,
   input wire logic [31:0] i_wdata,
   input wire logic o_rvalid,
   input wire logic o_undefined,
   // Walk and state
   input wire logic i_walk_req,
   input wire logic [31:0] i_walk_vaddr,
   input wire logic o_walk_valid,
   input wire logic o_walk_use_system,
   input wire logic [1:0] o_walk_outer_attr,
   input wire logic o_walk_l1_bypass,
   input wire logic [31:0] o_process_table_base,
   input wire logic [31:0] o_system_table_base,
   input wire logic [2:0] o_table_boundary_control
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire logic wr = i_xfer_valid && i_privileged && i_xfer_write && i_opc1 == 3'h0
      && i_primary_coproc_reg == 4'h2 && i_secondary_coproc_reg == 4'h0;
   property p_undef; o_undefined |-> $past(i_xfer_valid && !i_privileged); endproperty
   a_undef: assert property (p_undef) else $error("stray undefined");
   property p_read; o_rvalid |-> $past(i_xfer_valid && i_privileged && !i_xfer_write); endproperty
   a_read: assert property (p_read) else $error("stray read answer");
   property p_keep; i_xfer_valid && !i_privileged |=> $stable(o_process_table_base)
      && $stable(o_system_table_base); endproperty
   a_keep: assert property (p_keep) else $error("user access changed a base");
   property p_sys; wr && i_opc2 == 3'h1 |=> o_system_table_base == ($past(i_wdata) & 32'hffff_c01b);
   endproperty
   a_sys: assert property (p_sys) else $error("system base write wrong");
   property p_proc; wr && i_opc2 == 3'h0 |=> (o_process_table_base & 32'hffff_c01b)
      == ($past(i_wdata) & 32'hffff_c01b); endproperty
   a_proc: assert property (p_proc) else $error("process base write wrong");
   property p_l1; i_rst_n |-> o_walk_l1_bypass; endproperty
   a_l1: assert property (p_l1) else $error("walk may use level one cache");
   property p_sel; i_walk_req |=> o_walk_use_system == ($past(o_table_boundary_control) != 3'h0
      && ($past(i_walk_vaddr) >> (32 - $past(o_table_boundary_control))) != 32'h0); endproperty
   a_sel: assert property (p_sel) else $error("wrong base chosen");
   property p_outer; o_walk_use_system |-> o_walk_outer_attr != 2'h0; endproperty
   a_outer: assert property (p_outer) else $error("system walk not outer cacheable");
   property p_wvalid; o_walk_valid == $past(i_walk_req); endproperty
   a_wvalid: assert property (p_wvalid) else $error("walk answer out of step");
   property p_rst; $rose(i_rst_n) |-> o_table_boundary_control == 3'h0; endproperty
   a_rst: assert property (p_rst) else $error("boundary not zero after reset");
endmodule : table_base_regs_asserts

// ---- tb/table_base_regs_tb.sv ----
// Purpose: Self-checking bench of the table base register bank.
// Assumes: Answers and walk results are registered one edge after the strobe.
// Notes: Opcode 1, primary and secondary selectors stay at the mapped values.
`timescale 1ns/1ps
module table_base_regs_tb;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_xfer_valid = 1'b0, i_xfer_write = 1'b0;
   logic i_privileged = 1'b0, i_walk_req = 1'b0;
   logic [2:0] i_opc1 = 3'h0, i_opc2 = 3'h0;
   logic [3:0] i_primary_coproc_reg = 4'h2, i_secondary_coproc_reg = 4'h0;
   logic [31:0] i_wdata = 32'h0, i_walk_vaddr = 32'h0;
   logic o_rvalid, o_undefined, o_walk_valid, o_walk_use_system, o_walk_shared;
   logic o_walk_inner_cache, o_walk_l1_bypass, rv, ud;
   logic [1:0] o_walk_outer_attr;
   logic [2:0] o_table_boundary_control;
   logic [31:0] o_rdata, o_walk_addr, o_process_table_base, o_system_table_base, rd;
   int n_mismatch = 0;
   int comparisons = 0;
   always #50 i_clk = ~i_clk;
   table_base_regs table_base_regs_i (.i_clk, .i_rst_n, .i_xfer_valid, .i_xfer_write,
      .i_privileged, .i_opc1, .i_primary_coproc_reg, .i_secondary_coproc_reg, .i_opc2,
      .i_wdata, .o_rvalid, .o_rdata, .o_undefined, .i_walk_req, .i_walk_vaddr, .o_walk_valid,
      .o_walk_addr, .o_walk_use_system, .o_walk_outer_attr, .o_walk_shared,
      .o_walk_inner_cache, .o_walk_l1_bypass, .o_process_table_base, .o_system_table_base,
      .o_table_boundary_control);
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cop(input logic wr, input logic pr, input logic [2:0] op, input logic [31:0] d);
      @(posedge i_clk);
      i_xfer_valid <= 1'b1;
      i_xfer_write <= wr;
      i_privileged <= pr;
      i_opc2 <= op;
      i_wdata <= d;
      @(posedge i_clk);
      i_xfer_valid <= 1'b0;
      #1;
      rv = o_rvalid;
      ud = o_undefined;
      rd = o_rdata;
   endtask : cop
   task automatic walk(input logic [31:0] va, input logic sys, input logic [1:0] attr,
      input logic [1:0] si, input logic [31:0] addr);
      logic [32:0] got;
      @(posedge i_clk);
      i_walk_req <= 1'b1;
      i_walk_vaddr <= va;
      @(posedge i_clk);
      i_walk_req <= 1'b0;
      #1;
      got = {o_walk_l1_bypass, o_walk_valid, 28'h0, o_walk_use_system, o_walk_outer_attr};
      chk(got, {2'h3, 28'h0, sys, attr});
      chk({31'h0, o_walk_shared, o_walk_inner_cache}, {31'h0, si});
      chk({1'h0, o_walk_addr}, {1'h0, addr});
   endtask : walk
   task automatic t_reset;
      for (int k = 0; k < 3; k++) begin
         cop(1'b0, 1'b1, 3'(k), 32'h0);
         chk({rv, rd}, {1'b1, 32'h0});
      end
   endtask : t_reset
   task automatic t_process;
      for (int n = 0; n < 8; n++) begin
         cop(1'b1, 1'b1, 3'h2, 32'(n));
         cop(1'b1, 1'b1, 3'h0, 32'hffff_ffff);
         cop(1'b0, 1'b1, 3'h0, 32'h0);
         chk({rv, rd}, {1'b1, (32'hffff_ffff << (14 - n)) | 32'h1b});
         cop(1'b0, 1'b1, 3'h2, 32'h0);
         chk({rv, rd}, {1'b1, 32'(n)});
      end
      cop(1'b1, 1'b1, 3'h2, 32'h0);
   endtask : t_process
   task automatic t_system;
      cop(1'b1, 1'b1, 3'h1, 32'hffff_ffff);
      cop(1'b0, 1'b1, 3'h1, 32'h0);
      chk({rv, rd}, {1'b1, 32'hffff_c01b});
   endtask : t_system
   task automatic t_user;
      cop(1'b1, 1'b0, 3'h0, 32'h0);
      chk({ud, 31'h0, rv}, {1'b1, 32'h0});
      cop(1'b0, 1'b0, 3'h1, 32'h0);
      chk({ud, 31'h0, rv}, {1'b1, 32'h0});
      cop(1'b0, 1'b1, 3'h0, 32'h0);
      chk({rv, rd}, {1'b1, 32'hffff_c01b});
      cop(1'b0, 1'b1, 3'h3, 32'h0);
      chk({rv | ud, rd}, {1'b0, 32'h0});
   endtask : t_user
   task automatic t_walk;
      for (int a = 0; a < 4; a++) begin
         cop(1'b1, 1'b1, 3'h1, 32'h8000_4000 | (32'(a) << 3) | 32'(a));
         cop(1'b1, 1'b1, 3'h0, 32'h4000_0f80 | (32'(a) << 3) | 32'(a));
         cop(1'b1, 1'b1, 3'h2, 32'h7);
         walk(32'hffff_ffff, 1'b1, (a == 0) ? 2'h3 : 2'(a), 2'(a), 32'h8000_7ffc);
         walk(32'h01ff_ffff, 1'b0, 2'(a), 2'(a), 32'h4000_0ffc);
         cop(1'b1, 1'b1, 3'h2, 32'h0);
         walk(32'hffff_ffff, 1'b0, 2'(a), 2'(a), 32'h4000_3ffc);
      end
   endtask : t_walk
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      t_reset();
      t_process();
      t_system();
      t_user();
      t_walk();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_mismatch++;
      conclude();
   end
endmodule : table_base_regs_tb
bind table_base_regs table_base_regs_asserts table_base_regs_asserts_i (.i_clk, .i_rst_n,
   .i_xfer_valid, .i_xfer_write, .i_privileged, .i_opc1, .i_primary_coproc_reg,
   .i_secondary_coproc_reg, .i_opc2, .i_wdata, .o_rvalid, .o_undefined, .i_walk_req,
   .i_walk_vaddr, .o_walk_valid, .o_walk_use_system, .o_walk_outer_attr, .o_walk_l1_bypass,
   .o_process_table_base, .o_system_table_base, .o_table_boundary_control);
